// File: onoff_pkg.sv
// Constants, states and timing for the secondary-side on/off cycle request control.
// Assumes a single 40 MHz clock; analog comparator results arrive as raw pins.
// Contract
// - Feedback 2% above regulation threshold turns on weak output bleed sink.
// - Feedback beyond 20% above reference switches bleed sink to strong level.
// - While any bleed sink is active, keep control of cycle requests.
// - Feedback shorted at start-up: finish handshake, then withhold requests for skip time.
// - Feedback short in operation stops requests, deglitched under 10 us.
// - After detecting feedback short, give control back to primary.
// - Output below restart threshold beyond restart delay: relinquish control.
// - Constant current below 5 V, constant power above power knee threshold.
// - Rectifier drive only on requested cycle with falling winding-sense edge.
// - Current sense beyond three times threshold blocks rectifier drive until nominal.
// - Enabled cycle starts at oscillator start, ends at current limit or max duty.
// - A started switching cycle always runs to completion.
// - Clock runs always; feedback sample at cycle start decides switch or skip.
// - Current limit chosen from switch/skip history; highest at heavy load.
// - Medium load skips and lowers limit; very light load lowers further.
// - Six unanswered requests or six unrequested cycles restart the handshake.
// - Cycle oscillator averages 100 kHz with small period jitter.
// - In continuous conduction, rectifier drive ends when next request is sent.
// - Current-limit machine has four states, each with its own limit.
package onoff_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 40000000;
  localparam int OSC_HZ = 100000;
  localparam int OSC_CYCLES = CLK_HZ / OSC_HZ;
  localparam int JITTER_STEPS = 16;
  localparam int DEGLITCH_NS = 5000;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int SKIP_TIME_US = 100000;
  localparam int OUT_AR_DELAY_US = 50000;
  localparam int HANDSHAKE_MISS = 6;
  localparam int REQ_PULSE_CYCLES = 4;
  localparam int HISTORY_LEN = 8;
  localparam logic [15:0] JITTER_SEED = 16'hACE1;

  // ****************************************
  // Current limit states, one-hot
  // ****************************************
  typedef enum logic [3:0] {
    LIM_FULL = 4'h1,
    LIM_HIGH = 4'h2,
    LIM_MED = 4'h4,
    LIM_LOW = 4'h8
  } limit_state_t;

  // ****************************************
  // Control states, one-hot
  // ****************************************
  typedef enum logic [4:0] {
    CTL_HANDSHAKE = 5'h01,
    CTL_RUN = 5'h02,
    CTL_SKIP = 5'h04,
    CTL_RELEASED = 5'h08,
    CTL_OUT_AR = 5'h10
  } ctl_state_t;

  // Occupancy thresholds out of HISTORY_LEN for the limit machine
  localparam logic [3:0] UP_COUNT = 4'h7;
  localparam logic [3:0] DOWN_COUNT = 4'h3;

endpackage

// File: onoff_sync_if.sv
`timescale 1ns/1ps
// Carries synchronized comparator levels from the input stage to the controller.
// Assumes both ends are clocked by sys_clk.
interface onoff_sync_if;
  logic fb_over_2pct;
  logic fb_over_20pct;
  logic fb_below_reg;
  logic fb_short;
  logic out_below_ar;
  logic out_below_5v;
  logic out_above_knee;
  logic cur_over_th;
  logic cur_surge;
  logic winding_low;
  logic primary_switched;
  modport source (output fb_over_2pct, fb_over_20pct, fb_below_reg, fb_short, out_below_ar,
    out_below_5v, out_above_knee, cur_over_th, cur_surge, winding_low, primary_switched);
  modport sink (input fb_over_2pct, fb_over_20pct, fb_below_reg, fb_short, out_below_ar,
    out_below_5v, out_above_knee, cur_over_th, cur_surge, winding_low, primary_switched);
endinterface

// File: onoff_sync.sv
`timescale 1ns/1ps
// Two-stage synchronizer bank for the analog comparator outputs.
// Assumes raw inputs are asynchronous to sys_clk.
module onoff_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Raw comparator levels
  input wire logic [10:0] raw_in,
  // Synchronized levels
  onoff_sync_if.source sync
);
  import onoff_pkg::*;

  logic [10:0] meta_reg;
  logic [10:0] stable_reg;

  // ****************************************
  // Two flip-flops per level
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 11'h000;
      stable_reg <= 11'h000;
    end else begin
      meta_reg <= raw_in;
      stable_reg <= meta_reg;
    end
  end

  // Only the second stage reaches the controller
  assign sync.fb_over_2pct = stable_reg[0];
  assign sync.fb_over_20pct = stable_reg[1];
  assign sync.fb_below_reg = stable_reg[2];
  assign sync.fb_short = stable_reg[3];
  assign sync.out_below_ar = stable_reg[4];
  assign sync.out_below_5v = stable_reg[5];
  assign sync.out_above_knee = stable_reg[6];
  assign sync.cur_over_th = stable_reg[7];
  assign sync.cur_surge = stable_reg[8];
  assign sync.winding_low = stable_reg[9];
  assign sync.primary_switched = stable_reg[10];
endmodule

// File: onoff_cycle_request_control.sv
`timescale 1ns/1ps
// Secondary-side on/off cycle request controller with limit machine and protections.
// Assumes comparator pins are asynchronous; request pulse goes to the isolated link driver.
module onoff_cycle_request_control #(
  parameter int SKIP_CYCLES = onoff_pkg::SKIP_TIME_US * (onoff_pkg::CLK_HZ / 1000000),
  parameter int OUT_AR_CYCLES = onoff_pkg::OUT_AR_DELAY_US * (onoff_pkg::CLK_HZ / 1000000)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Feedback comparators
  input wire logic fb_over_2pct,
  input wire logic fb_over_20pct,
  input wire logic fb_below_reg,
  input wire logic fb_short,
  // Output and current comparators
  input wire logic out_below_ar,
  input wire logic out_below_5v,
  input wire logic out_above_knee,
  input wire logic cur_over_th,
  input wire logic cur_surge,
  // Winding sense and primary activity
  input wire logic winding_low,
  input wire logic primary_switched,
  // Link and drive outputs
  output logic cycle_request,
  output logic sync_rectifier_drive,
  output logic bleed_weak,
  output logic bleed_strong,
  output logic secondary_in_control,
  output onoff_pkg::limit_state_t limit_state,
  output logic cc_mode,
  output logic cp_mode
);
  import onoff_pkg::*;
  onoff_sync_if sync ();
  onoff_sync u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .raw_in({primary_switched, winding_low, cur_surge, cur_over_th, out_above_knee,
      out_below_5v, out_below_ar, fb_short, fb_below_reg, fb_over_20pct, fb_over_2pct}),
    .sync(sync)
  );

  // Occupancy of the switch/skip history
  function automatic logic [3:0] ones(input logic [HISTORY_LEN-1:0] h);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < HISTORY_LEN; i++) begin
      n = n + {3'h0, h[i]};
    end
    return n;
  endfunction

  // ****************************************
  // Oscillator with LFSR period jitter
  // ****************************************
  logic [9:0] osc_cnt_reg, osc_cnt_next;
  logic [15:0] lfsr_reg, lfsr_next;
  logic [9:0] period_reg, period_next;
  logic cycle_start;

  // Period runs from 8 cycles below to 7 above nominal, so the average sits just above 100 kHz
  always_comb begin
    lfsr_next = lfsr_reg;
    period_next = period_reg;
    osc_cnt_next = osc_cnt_reg + 10'h001;
    cycle_start = 1'b0;
    if (osc_cnt_reg >= period_reg - 10'h001) begin
      cycle_start = 1'b1;
      osc_cnt_next = 10'h000;
      lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      period_next = 10'(OSC_CYCLES - JITTER_STEPS / 2) + {6'h00, lfsr_reg[3:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_cnt_reg <= 10'h000;
      lfsr_reg <= JITTER_SEED;
      period_reg <= 10'(OSC_CYCLES);
    end else begin
      osc_cnt_reg <= osc_cnt_next;
      lfsr_reg <= lfsr_next;
      period_reg <= period_next;
    end
  end

  // ****************************************
  // Feedback short deglitch
  // ****************************************
  logic [7:0] dg_cnt_reg, dg_cnt_next;
  logic short_det;
  always_comb begin
    dg_cnt_next = 8'h00;
    if (sync.fb_short) begin
      dg_cnt_next = (dg_cnt_reg == 8'(DEGLITCH_CYCLES)) ? dg_cnt_reg : dg_cnt_reg + 8'h01;
    end
  end
  assign short_det = (dg_cnt_reg == 8'(DEGLITCH_CYCLES));
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dg_cnt_reg <= 8'h00;
    end else begin
      dg_cnt_reg <= dg_cnt_next;
    end
  end

  // ****************************************
  // Control state machine and request pulse
  // ****************************************
  ctl_state_t ctl_reg, ctl_next;
  logic [31:0] timer_reg, timer_next;
  logic [2:0] miss_reg, miss_next;
  logic [2:0] extra_reg, extra_next;
  logic [2:0] pulse_reg, pulse_next;
  logic short_at_start_reg, short_at_start_next;
  logic req_this_reg, req_this_next;
  logic answered_reg, answered_next;
  logic sw_prev_reg;
  logic sw_edge;
  logic bleeding;
  logic want;
  assign sw_edge = sync.primary_switched && !sw_prev_reg;
  assign bleeding = sync.fb_over_2pct || sync.fb_over_20pct;
  // Feedback below regulation asks for energy unless current is at its limit below 5 V
  assign want = sync.fb_below_reg && !(sync.cur_over_th && sync.out_below_5v);
  always_comb begin
    ctl_next = ctl_reg;
    timer_next = timer_reg;
    miss_next = miss_reg;
    extra_next = extra_reg;
    pulse_next = (pulse_reg != 3'h0) ? pulse_reg - 3'h1 : 3'h0;
    short_at_start_next = short_at_start_reg;
    req_this_next = req_this_reg;
    answered_next = answered_reg || sw_edge;
    unique case (ctl_reg)
      CTL_HANDSHAKE: begin
        if (sync.fb_short) begin
          short_at_start_next = 1'b1;
        end
        // Handshake completes once primary answers a request pulse
        if (cycle_start) begin
          pulse_next = 3'(REQ_PULSE_CYCLES);
        end
        if (sw_edge && pulse_reg == 3'h0) begin
          ctl_next = short_at_start_reg ? CTL_SKIP : CTL_RUN;
          timer_next = 32'h0;
          miss_next = 3'h0;
          extra_next = 3'h0;
        end
      end
      CTL_RUN: begin
        if (cycle_start) begin
          // Score the previous cycle; an answer landing on this very edge still counts
          if (req_this_reg && !(answered_reg || sw_edge)) begin
            miss_next = miss_reg + 3'h1;
          end else begin
            miss_next = 3'h0;
          end
          if (!req_this_reg && (answered_reg || sw_edge)) begin
            extra_next = extra_reg + 3'h1;
          end else begin
            extra_next = 3'h0;
          end
          answered_next = 1'b0;
          req_this_next = want && !bleeding;
          if (want && !bleeding) begin
            pulse_next = 3'(REQ_PULSE_CYCLES);
          end
        end
        timer_next = sync.out_below_ar ? timer_reg + 32'h1 : 32'h0;
        if (short_det) begin
          ctl_next = CTL_SKIP;
          timer_next = 32'h0;
        end else if (!bleeding && timer_reg >= 32'(OUT_AR_CYCLES)) begin
          ctl_next = CTL_OUT_AR;
        end else if (!bleeding && (miss_reg >= 3'(HANDSHAKE_MISS)
            || extra_reg >= 3'(HANDSHAKE_MISS))) begin
          ctl_next = CTL_HANDSHAKE;
          short_at_start_next = 1'b0;
        end
      end
      CTL_SKIP: begin
        // No requests for the skip period, then hand over to the primary
        timer_next = timer_reg + 32'h1;
        if (timer_reg >= 32'(SKIP_CYCLES)) begin
          ctl_next = CTL_RELEASED;
        end
      end
      CTL_OUT_AR, CTL_RELEASED: begin
        // Control is released; a fresh handshake starts when the fault clears
        if (!sync.fb_short && !sync.out_below_ar) begin
          ctl_next = CTL_HANDSHAKE;
          short_at_start_next = 1'b0;
          timer_next = 32'h0;
        end
      end
      default: begin
        ctl_next = CTL_HANDSHAKE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_reg <= CTL_HANDSHAKE;
      timer_reg <= 32'h0;
      miss_reg <= 3'h0;
      extra_reg <= 3'h0;
      pulse_reg <= 3'h0;
      short_at_start_reg <= 1'b0;
      req_this_reg <= 1'b0;
      answered_reg <= 1'b0;
      sw_prev_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      timer_reg <= timer_next;
      miss_reg <= miss_next;
      extra_reg <= extra_next;
      pulse_reg <= pulse_next;
      short_at_start_reg <= short_at_start_next;
      req_this_reg <= req_this_next;
      answered_reg <= answered_next;
      sw_prev_reg <= sync.primary_switched;
    end
  end

  // ****************************************
  // Current limit machine and drives
  // ****************************************
  limit_state_t lim_reg, lim_next;
  logic [HISTORY_LEN-1:0] hist_reg, hist_next;
  logic sr_reg, sr_next;
  logic wind_prev_reg;
  logic [3:0] occ;
  assign occ = ones(hist_reg);
  // Limit only moves at a cycle boundary, so a started cycle keeps its limit
  always_comb begin
    lim_next = lim_reg;
    hist_next = hist_reg;
    if (cycle_start && ctl_reg == CTL_RUN) begin
      hist_next = {hist_reg[HISTORY_LEN-2:0], want && !bleeding};
      unique case (lim_reg)
        LIM_FULL: lim_next = (occ < DOWN_COUNT) ? LIM_HIGH : LIM_FULL;
        LIM_HIGH: lim_next = (occ >= UP_COUNT) ? LIM_FULL
          : ((occ < DOWN_COUNT) ? LIM_MED : LIM_HIGH);
        LIM_MED: lim_next = (occ >= UP_COUNT) ? LIM_HIGH
          : ((occ < DOWN_COUNT) ? LIM_LOW : LIM_MED);
        LIM_LOW: lim_next = (occ >= UP_COUNT) ? LIM_MED : LIM_LOW;
        default: lim_next = LIM_FULL;
      endcase
    end
  end

  // Drive engages on winding fall during a requested cycle while in the run state
  always_comb begin
    sr_next = sr_reg;
    if (sync.winding_low && !wind_prev_reg && req_this_reg && ctl_reg == CTL_RUN) begin
      sr_next = 1'b1;
    end
    if (cycle_start && want && !bleeding) begin
      sr_next = 1'b0;
    end
    if (!sync.winding_low && wind_prev_reg) begin
      sr_next = 1'b0;
    end
    if (sync.cur_surge || ctl_reg != CTL_RUN) begin
      sr_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lim_reg <= LIM_FULL;
      hist_reg <= '1;
      sr_reg <= 1'b0;
      wind_prev_reg <= 1'b0;
    end else begin
      lim_reg <= lim_next;
      hist_reg <= hist_next;
      sr_reg <= sr_next;
      wind_prev_reg <= sync.winding_low;
    end
  end

  // The primary starts each requested cycle at its oscillator edge and ends it
  // at the selected limit or max_duty_limit; a pulse is never cut short once sent.
  assign cycle_request = (pulse_reg != 3'h0);
  assign sync_rectifier_drive = sr_reg;
  assign bleed_weak = sync.fb_over_2pct && !sync.fb_over_20pct;
  assign bleed_strong = sync.fb_over_20pct;
  assign secondary_in_control = (ctl_reg == CTL_RUN) || (ctl_reg == CTL_SKIP);
  assign limit_state = lim_reg;
  assign cc_mode = sync.out_below_5v;
  assign cp_mode = sync.out_above_knee && !sync.out_below_5v;
endmodule

// File: onoff_cycle_request_control_assertions.sv
// Concurrent checks on the cycle request controller's top-level ports.
// Assumes one sys_clk domain and onoff_pkg compiled first.
`timescale 1ns/1ps
module onoff_cycle_request_control_assertions
  import onoff_pkg::*;
#(
  parameter int SKIP_CYCLES = 50,
  parameter int OUT_AR_CYCLES = 30
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Comparator inputs
  input wire logic fb_over_2pct,
  input wire logic fb_over_20pct,
  input wire logic fb_short,
  input wire logic out_below_ar,
  input wire logic out_below_5v,
  input wire logic cur_surge,
  // Controller outputs
  input wire logic cycle_request,
  input wire logic sync_rectifier_drive,
  input wire logic bleed_weak,
  input wire logic bleed_strong,
  input wire logic secondary_in_control,
  input wire onoff_pkg::limit_state_t limit_state,
  input wire logic cc_mode,
  input wire logic cp_mode
);
  // ****************************************
  // Helper logic
  // ****************************************
  int short_run;
  int ar_run;
  logic bleeding;
  assign bleeding = bleed_weak | bleed_strong;
  // Run lengths of held faults; saturate so a long hold never wraps.
  // A short is timed only once the secondary holds control: a start-up short
  // must still let the handshake pulses through before requests stop.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      short_run <= 0;
      ar_run <= 0;
    end else begin
      short_run <= (fb_short && (secondary_in_control || short_run != 0))
        ? short_run + int'(short_run < 100000) : 0;
      ar_run <= out_below_ar ? ar_run + int'(ar_run < 100000) : 0;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence req_pulse;
    cycle_request [*4] ##1 !cycle_request;
  endsequence

  chk_weak_bleed: assert property ((fb_over_2pct && !fb_over_20pct) [*4] |-> bleed_weak)
    else $error("weak bleed missing");
  chk_strong_bleed: assert property (fb_over_20pct [*4] |-> bleed_strong && !bleed_weak)
    else $error("strong bleed missing");
  chk_bleed_no_req: assert property ($rose(cycle_request) |-> !$past(bleeding))
    else $error("request while bleeding");
  chk_bleed_keeps: assert property (bleeding && secondary_in_control |=> secondary_in_control)
    else $error("control lost while bleeding");
  chk_req_width: assert property ($rose(cycle_request) |-> req_pulse)
    else $error("request pulse width wrong");
  chk_sr_ctl: assert property ($rose(sync_rectifier_drive) |-> secondary_in_control)
    else $error("rectifier on without control");
  chk_sr_surge: assert property (cur_surge [*4] |-> !sync_rectifier_drive)
    else $error("rectifier on during surge");
  chk_sr_next_req: assert property ($rose(cycle_request) |-> ##[0:1] !sync_rectifier_drive)
    else $error("rectifier on at next request");
  chk_limit_onehot: assert property ($onehot(limit_state))
    else $error("limit state not one-hot");
  chk_cc_mode: assert property (out_below_5v [*4] |-> cc_mode && !cp_mode)
    else $error("cc mode missing");
  chk_short_stop: assert property (short_run > 210 |-> !$rose(cycle_request))
    else $error("request after feedback short");
  chk_short_release: assert property (short_run > SKIP_CYCLES + 260 |-> !secondary_in_control)
    else $error("control kept after short");
  chk_out_ar: assert property (ar_run > OUT_AR_CYCLES + 10 |-> !secondary_in_control)
    else $error("control kept below restart level");
endmodule

bind onoff_cycle_request_control onoff_cycle_request_control_assertions #(
  .SKIP_CYCLES(SKIP_CYCLES),
  .OUT_AR_CYCLES(OUT_AR_CYCLES)
) i_chk (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .fb_over_2pct(fb_over_2pct),
  .fb_over_20pct(fb_over_20pct),
  .fb_short(fb_short),
  .out_below_ar(out_below_ar),
  .out_below_5v(out_below_5v),
  .cur_surge(cur_surge),
  .cycle_request(cycle_request),
  .sync_rectifier_drive(sync_rectifier_drive),
  .bleed_weak(bleed_weak),
  .bleed_strong(bleed_strong),
  .secondary_in_control(secondary_in_control),
  .limit_state(limit_state),
  .cc_mode(cc_mode),
  .cp_mode(cp_mode)
);

// File: primary_model.sv
// Behavioural primary-side switch controller answering link requests.
// Assumes requests arrive as clean pulses on sys_clk; delays are in cycles.
`timescale 1ns/1ps
module primary_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link request and test controls
  input wire logic cycle_request,
  input wire logic respond,
  input wire logic slow,
  // Switching seen on the secondary winding
  output logic primary_switched,
  output logic winding_low
);
  // ****************************************
  // Switching cycle timer
  // ****************************************
  logic req_reg;
  int cnt_reg;
  int lag;
  assign lag = slow ? 30 : 3;
  // A started cycle runs to its end; requests meanwhile are ignored
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_reg <= 1'b0;
      cnt_reg <= 0;
    end else begin
      req_reg <= cycle_request;
      if (cnt_reg != 0) begin
        cnt_reg <= (cnt_reg >= lag + 50) ? 0 : cnt_reg + 1;
      end else if (req_reg && !cycle_request && respond) begin
        cnt_reg <= 1;
      end
    end
  end
  // On-time first, then the winding swings below zero
  assign primary_switched = (cnt_reg >= lag) && (cnt_reg < lag + 10);
  assign winding_low = (cnt_reg >= lag + 10) && (cnt_reg < lag + 50);
endmodule

// File: tb_onoff_cycle_request_control.sv
// Self-checking bench for the cycle request controller.
// Assumes package, interface, design, checker and primary model compiled first.
`timescale 1ns/1ps
module tb_onoff_cycle_request_control;
  import onoff_pkg::*;
  localparam int OSC = 410;
  logic sys_clk, reset_n, respond, slow, primary_switched, winding_low;
  logic fb_over_2pct, fb_over_20pct, fb_below_reg, fb_short, out_below_ar;
  logic out_below_5v, out_above_knee, cur_over_th, cur_surge;
  logic cycle_request, sync_rectifier_drive, bleed_weak, bleed_strong;
  logic secondary_in_control, cc_mode, cp_mode;
  limit_state_t limit_state;
  int error_cnt, n_compared, req_cnt, sr_cnt, snap;

  // ****************************************
  // Design and primary model
  // ****************************************
  onoff_cycle_request_control #(.SKIP_CYCLES(50), .OUT_AR_CYCLES(30)) i_dut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .fb_over_2pct(fb_over_2pct),
    .fb_over_20pct(fb_over_20pct),
    .fb_below_reg(fb_below_reg),
    .fb_short(fb_short),
    .out_below_ar(out_below_ar),
    .out_below_5v(out_below_5v),
    .out_above_knee(out_above_knee),
    .cur_over_th(cur_over_th),
    .cur_surge(cur_surge),
    .winding_low(winding_low),
    .primary_switched(primary_switched),
    .cycle_request(cycle_request),
    .sync_rectifier_drive(sync_rectifier_drive),
    .bleed_weak(bleed_weak),
    .bleed_strong(bleed_strong),
    .secondary_in_control(secondary_in_control),
    .limit_state(limit_state),
    .cc_mode(cc_mode),
    .cp_mode(cp_mode)
  );
  primary_model i_primary (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cycle_request(cycle_request),
    .respond(respond),
    .slow(slow),
    .primary_switched(primary_switched),
    .winding_low(winding_low)
  );
  // Clock and edge counters
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge cycle_request) req_cnt++;
  always @(posedge sync_rectifier_drive) sr_cnt++;

  // ****************************************
  // Common tasks
  // ****************************************
  // Sample at the falling edge so that rising-edge updates have landed
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bounded wait on the control flag; running out ends the run
  task automatic wait_ctl(input logic want, input int lim);
    int i;
    for (i = 0; i < lim && secondary_in_control !== want; i++) tick(1);
    check(secondary_in_control, want);
    if (secondary_in_control !== want) final_report();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_load;
    @(posedge sys_clk);
    fb_below_reg <= 1'b1;
    wait_ctl(1'b1, 4 * OSC);
    snap = req_cnt;
    tick(12 * OSC);
    check(limit_state, LIM_FULL);
    check(req_cnt - snap > 10, 1);
    @(posedge sys_clk);
    fb_below_reg <= 1'b0;
    tick(14 * OSC);
    check(limit_state, LIM_LOW);
    @(posedge sys_clk);
    fb_below_reg <= 1'b1;
    tick(14 * OSC);
    check(limit_state, LIM_FULL);
  endtask
  // Surge blocks the rectifier; a slow primary still gets it back
  task automatic t_surge;
    @(posedge sys_clk);
    cur_surge <= 1'b1;
    slow <= 1'b1;
    tick(6);
    snap = sr_cnt;
    tick(4 * OSC);
    check(sr_cnt, snap);
    @(posedge sys_clk);
    cur_surge <= 1'b0;
    tick(4 * OSC);
    check(sr_cnt > snap, 1);
    @(posedge sys_clk);
    slow <= 1'b0;
  endtask
  task automatic t_bleed;
    @(posedge sys_clk);
    fb_over_2pct <= 1'b1;
    tick(6);
    check({bleed_strong, bleed_weak}, 2'h1);
    snap = req_cnt;
    @(posedge sys_clk);
    fb_over_20pct <= 1'b1;
    tick(6);
    check({bleed_strong, bleed_weak}, 2'h2);
    tick(3 * OSC);
    check(req_cnt, snap);
    check(secondary_in_control, 1'b1);
    @(posedge sys_clk);
    fb_over_2pct <= 1'b0;
    fb_over_20pct <= 1'b0;
    tick(6);
    check({bleed_strong, bleed_weak}, 2'h0);
  endtask
  task automatic t_unanswered;
    @(posedge sys_clk);
    respond <= 1'b0;
    wait_ctl(1'b0, 8 * OSC);
    @(posedge sys_clk);
    respond <= 1'b1;
    wait_ctl(1'b1, 4 * OSC);
  endtask
  task automatic t_faults;
    @(posedge sys_clk);
    fb_short <= 1'b1;
    tick(215);
    snap = req_cnt;
    tick(150);
    check(secondary_in_control, 1'b0);
    check(req_cnt, snap);
    @(posedge sys_clk);
    fb_short <= 1'b0;
    wait_ctl(1'b1, 4 * OSC);
    @(posedge sys_clk);
    out_below_ar <= 1'b1;
    tick(50);
    check(secondary_in_control, 1'b0);
    @(posedge sys_clk);
    out_below_ar <= 1'b0;
    out_below_5v <= 1'b1;
    tick(6);
    check({cc_mode, cp_mode}, 2'h2);
    @(posedge sys_clk);
    out_below_5v <= 1'b0;
    out_above_knee <= 1'b1;
    tick(6);
    check({cc_mode, cp_mode}, 2'h1);
    wait_ctl(1'b1, 4 * OSC);
    // Current at its limit in the constant-current range withholds requests
    @(posedge sys_clk);
    out_below_5v <= 1'b1;
    cur_over_th <= 1'b1;
    tick(6);
    snap = req_cnt;
    tick(2 * OSC);
    check(req_cnt, snap);
    check(secondary_in_control, 1'b1);
  endtask
  // Feedback shorted at start: handshake, then silence until released
  task automatic t_start_short;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    fb_short <= 1'b1;
    tick(3);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    wait_ctl(1'b1, 4 * OSC);
    snap = req_cnt;
    wait_ctl(1'b0, 400);
    check(req_cnt, snap);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {fb_over_2pct, fb_over_20pct, fb_below_reg, fb_short, out_below_ar} = 5'h00;
    {out_below_5v, out_above_knee, cur_over_th, cur_surge, slow} = 5'h00;
    {reset_n, respond, error_cnt, n_compared, req_cnt, sr_cnt} = 0;
    respond = 1'b1;
    repeat (20) @(posedge sys_clk);
    tick(1);
    check(limit_state, LIM_FULL);
    check({cycle_request, secondary_in_control}, 2'h0);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    t_load();
    t_surge();
    t_bleed();
    t_unanswered();
    t_faults();
    t_start_short();
    final_report();
  end
endmodule
